// ==== rtl/tcv_pkg.sv ====
/*
 * tcv_pkg: constants, register map and carrier types of the timer
 * capture / vector / divider block.
 * assumes: AXI4-Lite register access, byte address = 4 * register index.
 */
package tcv_pkg;
    localparam int unsigned TCV_NCH = 6;
    localparam int unsigned TCV_AW = 12;
    // register indices, byte address is four times the index
    localparam logic [5:0] TCV_IDX_CTL = 6'h00;
    localparam logic [5:0] TCV_IDX_CCTL1 = 6'h04;
    localparam logic [5:0] TCV_IDX_CCTL6 = 6'h0E;
    localparam logic [5:0] TCV_IDX_CNT = 6'h10;
    localparam logic [5:0] TCV_IDX_CCR1 = 6'h14;
    localparam logic [5:0] TCV_IDX_CCR6 = 6'h1E;
    localparam logic [5:0] TCV_IDX_EX = 6'h20;
    localparam logic [5:0] TCV_IDX_IV = 6'h2E;
    localparam logic [5:0] TCV_IDX_ISR = 6'h30;
    localparam logic [5:0] TCV_IDX_IMR = 6'h32;
    // control register fields
    localparam int unsigned TCV_CTL_ROLL_FLAG = 0;
    localparam int unsigned TCV_CTL_ROLL_IE = 1;
    localparam int unsigned TCV_CTL_CLEAR = 2;
    localparam int unsigned TCV_CTL_RUN = 4;
    localparam int unsigned TCV_CTL_PRE_LSB = 6;
    // channel control fields
    localparam int unsigned TCV_CC_FLAG = 0;
    localparam int unsigned TCV_CC_OVF = 1;
    localparam int unsigned TCV_CC_IE = 4;
    localparam int unsigned TCV_CC_CSEL = 8;
    // expansion register field
    localparam int unsigned TCV_EX_W = 3;
    // vector codes
    localparam logic [15:0] TCV_VEC_NONE = 16'h0000;
    localparam logic [15:0] TCV_VEC_ROLL = 16'h000E;
    // reset values
    localparam logic [15:0] TCV_RST_WORD = 16'h0000;
    localparam logic [2:0] TCV_RST_DIV = 3'h0;
    // bus responses
    localparam logic [1:0] TCV_RESP_OK = 2'h0;
    localparam logic [1:0] TCV_RESP_ERR = 2'h2;

    typedef enum logic [3:0] {
        TCV_K_NONE = 4'b0000,
        TCV_K_CTL = 4'b0001,
        TCV_K_CNT = 4'b0010,
        TCV_K_CCTL = 4'b0011,
        TCV_K_CCR = 4'b0100,
        TCV_K_EX = 4'b0101,
        TCV_K_IV = 4'b0110,
        TCV_K_ISR = 4'b0111,
        TCV_K_IMR = 4'b1000
    } tcv_kind_t;

    typedef struct packed {
        tcv_kind_t kind;
        logic [2:0] chan;
    } tcv_dec_t;

    typedef struct packed {
        logic cap_sel;
        logic ie;
        logic ovf;
        logic flag;
    } tcv_chan_t;

    typedef struct packed {
        logic [1:0] prescale_select;
        logic run;
        logic roll_ie;
        logic rollover_flag;
    } tcv_ctl_t;
endpackage

// ==== rtl/tcv_timer.sv ====
/*
 * tcv_timer: 16-bit timer tail with six capture/compare channels,
 * prioritised interrupt vector, two-stage input divider, AXI4-Lite slave.
 * assumes: single clock mclk, synchronous active-high reset, capture
 * inputs asynchronous to mclk.
 */
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module tcv_timer
    import tcv_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [TCV_NCH-1:0] cap_in,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [TCV_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [TCV_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic irq
);
    function automatic tcv_dec_t decode(input logic [TCV_AW-1:0] a);
        tcv_dec_t d;
        logic [5:0] i;
        d.kind = TCV_K_NONE;
        d.chan = 3'h0;
        i = a[7:2];
        if (a[TCV_AW-1:8] == '0) begin
            if (i == TCV_IDX_CTL) d.kind = TCV_K_CTL;
            else if (i == TCV_IDX_CNT) d.kind = TCV_K_CNT;
            else if (i == TCV_IDX_EX) d.kind = TCV_K_EX;
            else if (i == TCV_IDX_IV) d.kind = TCV_K_IV;
            else if (i == TCV_IDX_ISR) d.kind = TCV_K_ISR;
            else if (i == TCV_IDX_IMR) d.kind = TCV_K_IMR;
            else if (!i[0] && i >= TCV_IDX_CCTL1 && i <= TCV_IDX_CCTL6) begin
                d.kind = TCV_K_CCTL;
                d.chan = 3'((i - TCV_IDX_CCTL1) >> 1);
            end else if (!i[0] && i >= TCV_IDX_CCR1 && i <= TCV_IDX_CCR6) begin
                d.kind = TCV_K_CCR;
                d.chan = 3'((i - TCV_IDX_CCR1) >> 1);
            end
        end
        return d;
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) r[7:0] = wd[7:0];
        if (st[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    // pending sources: bit n-1 is channel n, bit 6 is rollover
    function automatic logic [15:0] vec_code(input logic [TCV_NCH:0] p);
        logic [15:0] v;
        v = TCV_VEC_NONE;
        for (int k = TCV_NCH; k >= 0; k--) begin
            if (p[k]) v = 16'(2 * (k + 1));
        end
        return v;
    endfunction

    // bus state
    logic aw_have_q, w_have_q, bvalid_q, awready_q, wready_q, arready_q, rvalid_q;
    logic [TCV_AW-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic irq_q;
    // timer state
    tcv_ctl_t ctl_q;
    tcv_chan_t ch_q [TCV_NCH];
    logic [15:0] ccr_q [TCV_NCH];
    logic [15:0] cnt_q;
    logic [2:0] idex_q, pre_cnt_q, ext_cnt_q;
    logic [TCV_NCH:0] ist_q, imask_q;
    logic [TCV_NCH-1:0] cap_s1_q, cap_s2_q, cap_s3_q;

    logic aw_take, w_take, wr_do, rd_take, clr, tick, pre_tick;
    logic aw_have_d, w_have_d, bvalid_d, rvalid_d;
    tcv_dec_t wdec, rdec;
    logic [TCV_NCH:0] pend, iv_clr;
    logic [15:0] vec_w, cnt_inc;
    logic [TCV_NCH-1:0] cap_ev, cmp_ev, ch_set;
    logic roll_set;
    logic [31:0] rd_w;

    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take = s_axi_wvalid && wready_q;
    assign wr_do = aw_have_q && w_have_q && !bvalid_q;
    assign rd_take = s_axi_arvalid && arready_q;
    assign aw_have_d = (aw_have_q || aw_take) && !wr_do;
    assign w_have_d = (w_have_q || w_take) && !wr_do;
    assign bvalid_d = wr_do || (bvalid_q && !s_axi_bready);
    assign rvalid_d = rd_take || (rvalid_q && !s_axi_rready);
    assign wdec = decode(awaddr_q);
    assign rdec = decode(s_axi_araddr);

    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= TCV_RESP_OK;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= !aw_have_d && !bvalid_d;
            wready_q <= !w_have_d && !bvalid_d;
            bvalid_q <= bvalid_d;
            if (aw_take) awaddr_q <= s_axi_awaddr;
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do) bresp_q <= (wdec.kind == TCV_K_NONE) ? TCV_RESP_ERR : TCV_RESP_OK;
        end
    end

    // read data mux
    always_comb begin
        rd_w = '0;
        case (rdec.kind)
            TCV_K_CTL: rd_w[15:0] = {8'h00, ctl_q.prescale_select, 1'b0, ctl_q.run, 2'b00,
                                     ctl_q.roll_ie, ctl_q.rollover_flag};
            TCV_K_CNT: rd_w[15:0] = cnt_q;
            TCV_K_CCTL: rd_w[15:0] = {7'h00, ch_q[rdec.chan].cap_sel, 3'h0, ch_q[rdec.chan].ie, 2'b00,
                                      ch_q[rdec.chan].ovf, ch_q[rdec.chan].flag};
            TCV_K_CCR: rd_w[15:0] = ccr_q[rdec.chan];
            TCV_K_EX: rd_w[15:0] = {13'h0000, idex_q};
            TCV_K_IV: rd_w[15:0] = vec_w;
            TCV_K_ISR: rd_w[TCV_NCH:0] = ist_q;
            TCV_K_IMR: rd_w[TCV_NCH:0] = imask_q;
            default: rd_w = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= TCV_RESP_OK;
        end else begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (rd_take) begin
                rdata_q <= rd_w;
                rresp_q <= (rdec.kind == TCV_K_NONE) ? TCV_RESP_ERR : TCV_RESP_OK;
            end
        end
    end

    // vector and its read-to-clear
    always_comb begin
        for (int k = 0; k < TCV_NCH; k++) pend[k] = ch_q[k].flag && ch_q[k].ie;
        pend[TCV_NCH] = ctl_q.rollover_flag && ctl_q.roll_ie;
        vec_w = vec_code(pend);
        iv_clr = '0;
        if (rd_take && rdec.kind == TCV_K_IV && vec_w != TCV_VEC_NONE) begin
            iv_clr[3'(vec_w[3:1] - 3'h1)] = 1'b1;
        end
    end

    // control register and clear strobe
    assign clr = wr_do && wdec.kind == TCV_K_CTL && wstrb_q[0] && wdata_q[TCV_CTL_CLEAR];
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctl_q <= '0;
        end else begin
            if (wr_do && wdec.kind == TCV_K_CTL && wstrb_q[0]) begin
                ctl_q.prescale_select <= wdata_q[TCV_CTL_PRE_LSB +: 2];
                ctl_q.run <= wdata_q[TCV_CTL_RUN];
                ctl_q.roll_ie <= wdata_q[TCV_CTL_ROLL_IE];
                ctl_q.rollover_flag <= wdata_q[TCV_CTL_ROLL_FLAG];
            end
            if (iv_clr[TCV_NCH]) ctl_q.rollover_flag <= 1'b0;
            if (roll_set) ctl_q.rollover_flag <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            idex_q <= TCV_RST_DIV;
        end else if (wr_do && wdec.kind == TCV_K_EX && wstrb_q[0]) begin
            idex_q <= wdata_q[TCV_EX_W-1:0];
        end
    end

    // divider: prescale down counter then extension down counter
    assign pre_tick = ctl_q.run && pre_cnt_q == 3'h0;
    assign tick = pre_tick && ext_cnt_q == 3'h0;
    always_ff @(posedge mclk) begin
        if (reset || clr) begin
            pre_cnt_q <= TCV_RST_DIV;
            ext_cnt_q <= TCV_RST_DIV;
        end else if (ctl_q.run) begin
            pre_cnt_q <= pre_tick ? 3'((4'h1 << ctl_q.prescale_select) - 4'h1) : pre_cnt_q - 3'h1;
            if (pre_tick) ext_cnt_q <= (ext_cnt_q == 3'h0) ? idex_q : ext_cnt_q - 3'h1;
        end
    end

    // counter, continuous up count
    assign cnt_inc = cnt_q + 16'h0001;
    assign roll_set = tick && cnt_q == 16'hFFFF;
    always_ff @(posedge mclk) begin
        if (reset || clr) begin
            cnt_q <= TCV_RST_WORD;
        end else if (wr_do && wdec.kind == TCV_K_CNT) begin
            cnt_q <= merge(cnt_q, wdata_q, wstrb_q);
        end else if (tick) begin
            cnt_q <= cnt_inc;
        end
    end

    // capture input synchroniser and edge detect
    always_ff @(posedge mclk) begin
        if (reset) begin
            cap_s1_q <= '0;
            cap_s2_q <= '0;
            cap_s3_q <= '0;
        end else begin
            cap_s1_q <= cap_in;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    always_comb begin
        for (int k = 0; k < TCV_NCH; k++) begin
            cap_ev[k] = ch_q[k].cap_sel && cap_s2_q[k] && !cap_s3_q[k];
            cmp_ev[k] = !ch_q[k].cap_sel && tick && cnt_inc == ccr_q[k];
            ch_set[k] = cap_ev[k] || cmp_ev[k];
        end
    end

    // channel control and value registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int k = 0; k < TCV_NCH; k++) begin
                ch_q[k] <= '0;
                ccr_q[k] <= TCV_RST_WORD;
            end
        end else begin
            for (int k = 0; k < TCV_NCH; k++) begin
                if (wr_do && wdec.kind == TCV_K_CCTL && wdec.chan == 3'(k)) begin
                    if (wstrb_q[1]) ch_q[k].cap_sel <= wdata_q[TCV_CC_CSEL];
                    if (wstrb_q[0]) begin
                        ch_q[k].ie <= wdata_q[TCV_CC_IE];
                        ch_q[k].ovf <= wdata_q[TCV_CC_OVF];
                        ch_q[k].flag <= wdata_q[TCV_CC_FLAG];
                    end
                end
                if (wr_do && wdec.kind == TCV_K_CCR && wdec.chan == 3'(k)) begin
                    ccr_q[k] <= merge(ccr_q[k], wdata_q, wstrb_q);
                end
                if (iv_clr[k]) ch_q[k].flag <= 1'b0;
                if (cap_ev[k]) begin
                    ccr_q[k] <= cnt_q;
                    if (ch_q[k].flag) ch_q[k].ovf <= 1'b1;
                end
                if (ch_set[k]) ch_q[k].flag <= 1'b1;
            end
        end
    end

    // system interrupt: sticky status, write one to clear, mask
    always_ff @(posedge mclk) begin
        if (reset) begin
            ist_q <= '0;
            imask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (wr_do && wdec.kind == TCV_K_IMR && wstrb_q[0]) imask_q <= wdata_q[TCV_NCH:0];
            ist_q <= (ist_q & ~((wr_do && wdec.kind == TCV_K_ISR && wstrb_q[0]) ? wdata_q[TCV_NCH:0] : '0))
                     | {roll_set, ch_set};
            irq_q <= |(ist_q & imask_q);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = irq_q;

    a_vec_empty: assert property (@(posedge mclk) disable iff (reset)
        rd_take && rdec.kind == TCV_K_IV && pend == '0 |=> s_axi_rdata == 32'h0000_0000)
        else $error("vector not zero with nothing pending");
    a_vec_top_chan: assert property (@(posedge mclk) disable iff (reset)
        rd_take && rdec.kind == TCV_K_IV && pend[0] |=> s_axi_rdata == 32'h0000_0002)
        else $error("channel 1 not reported as 02h");
    a_vec_roll: assert property (@(posedge mclk) disable iff (reset)
        rd_take && rdec.kind == TCV_K_IV && pend == 7'h40 |=> s_axi_rdata == 32'h0000_000E)
        else $error("rollover not reported as 0Eh");
    a_vec_prio: assert property (@(posedge mclk) disable iff (reset)
        rd_take && rdec.kind == TCV_K_IV && pend[2:0] == 3'b110 |=> s_axi_rdata == 32'h0000_0004)
        else $error("channel 2 did not beat channel 3");
    a_vec_bits: assert property (@(posedge mclk) disable iff (reset)
        rd_take && rdec.kind == TCV_K_IV |=> s_axi_rdata[31:4] == '0 && !s_axi_rdata[0])
        else $error("vector has bits outside 3..1");
    a_vec_clears: assert property (@(posedge mclk) disable iff (reset)
        rd_take && rdec.kind == TCV_K_IV && pend[0] && !ch_set[0] && !wr_do |=> !ch_q[0].flag)
        else $error("vector read did not clear channel 1 flag");
    a_ovf_hold: assert property (@(posedge mclk) disable iff (reset)
        ch_q[0].ovf && !(wr_do && wdec.kind == TCV_K_CCTL) |=> ch_q[0].ovf)
        else $error("overflow cleared without a write");
    a_ovf_set: assert property (@(posedge mclk) disable iff (reset)
        cap_ev[0] && ch_q[0].flag && !wr_do |=> ch_q[0].ovf && ch_q[0].flag)
        else $error("second capture did not flag overflow");
    a_cap_copy: assert property (@(posedge mclk) disable iff (reset)
        cap_ev[0] |=> ccr_q[0] == $past(cnt_q) && ch_q[0].flag)
        else $error("capture did not copy the counter");
    a_cmp_hit: assert property (@(posedge mclk) disable iff (reset)
        !ch_q[1].cap_sel && tick && cnt_inc == ccr_q[1] |=> ch_q[1].flag)
        else $error("compare match did not set the flag");
    a_clear_self: assert property (@(posedge mclk) disable iff (reset)
        clr |=> cnt_q == 16'h0000 && pre_cnt_q == 3'h0 ##1 !clr)
        else $error("clear strobe misbehaved");
    a_ex_zero: assert property (@(posedge mclk) disable iff (reset)
        rd_take && rdec.kind == TCV_K_EX |=> s_axi_rdata[31:3] == '0)
        else $error("expansion reserved bits not zero");
    a_div_gap: assert property (@(posedge mclk) disable iff (reset)
        tick && idex_q == 3'h1 && ctl_q.prescale_select == 2'h0 && !clr |=> !tick ##1 (tick || !ctl_q.run || clr))
        else $error("divide by two tick spacing wrong");
    a_pre_gap: assert property (@(posedge mclk) disable iff (reset)
        pre_tick && ctl_q.prescale_select == 2'h1 && !clr |=> !pre_tick)
        else $error("prescale by two ticked back to back");
endmodule

// ==== testbench/tcv_testbench.sv ====
/*
 * testbench: self-checking bench of tcv_timer, driving AXI4-Lite
 * register accesses and capture inputs directly.
 * assumes: tcv_pkg and tcv_timer compiled first, byte address = 4 * index.
 */
`timescale 1ns/100ps
module testbench
    import tcv_pkg::*;
;
    localparam logic [11:0] A_CTL = {4'h0, TCV_IDX_CTL, 2'b00};
    localparam logic [11:0] A_CNT = {4'h0, TCV_IDX_CNT, 2'b00};
    localparam logic [11:0] A_EX = {4'h0, TCV_IDX_EX, 2'b00};
    localparam logic [11:0] A_IV = {4'h0, TCV_IDX_IV, 2'b00};
    localparam logic [11:0] A_ISR = {4'h0, TCV_IDX_ISR, 2'b00};
    localparam logic [11:0] A_IMR = {4'h0, TCV_IDX_IMR, 2'b00};
    localparam logic [11:0] A_CCTL1 = {4'h0, TCV_IDX_CCTL1, 2'b00};
    localparam logic [11:0] A_CCR1 = {4'h0, TCV_IDX_CCR1, 2'b00};
    localparam logic [11:0] A_BAD = 12'hFFC;
    logic mclk, reset, irq;
    logic [TCV_NCH-1:0] cap_in;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [TCV_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] d;
    logic [1:0] r;

    tcv_timer DUT (.mclk(mclk), .reset(reset), .cap_in(cap_in),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(s_axi_awprot), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        @(posedge mclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, v};
        s_axi_wstrb <= 4'hF;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                r = s_axi_bresp;
                break;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge mclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
        end
    endtask

    task automatic pulse(input int ch);
        @(posedge mclk);
        cap_in[ch] <= 1'b1;
        repeat (4) @(posedge mclk);
        cap_in[ch] <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        int pre [4] = '{0, 1, 3, 0};
        int ex [4] = '{0, 2, 7, 1};
        int dv [4] = '{1, 6, 64, 2};
        reset = 1'b1;
        cap_in = '0;
        s_axi_awvalid = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awprot = 3'h0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_araddr = '0;
        s_axi_arprot = 3'h0;
        s_axi_rready = 1'b0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(A_IV); chk("vector reset", d, 32'h0);
        rd(A_EX); chk("expansion reset", d, 32'h0);
        rd(A_CCR1); chk("value reset", d, 32'h0);
        wr(A_EX, 16'hFFFF); rd(A_EX); chk("expansion bits", d, 32'h7);
        wr(A_IV, 16'hFFFF); rd(A_IV); chk("vector read only", d, 32'h0);
        wr(A_BAD, 16'h0001); chk("unmapped bresp", {30'h0, r}, {30'h0, TCV_RESP_ERR});
        rd(A_BAD); chk("unmapped rresp", {30'h0, r}, {30'h0, TCV_RESP_ERR});
        chk("unmapped data", d, 32'h0);
        // clear strobe
        wr(A_CNT, 16'h5555); rd(A_CNT); chk("counter write", d, 32'h5555);
        wr(A_CTL, 16'h0004); rd(A_CNT); chk("counter cleared", d, 32'h0);
        rd(A_CTL); chk("strobe reads zero", d, 32'h0);
        // capture, overflow
        wr(A_CCTL1, 16'h0100); wr(A_CNT, 16'h1234); pulse(0);
        rd(A_CCR1); chk("capture value", d, 32'h1234);
        rd(A_CCTL1); chk("capture flag", d, 32'h0101);
        wr(A_CNT, 16'h2222); pulse(0);
        rd(A_CCR1); chk("second capture", d, 32'h2222);
        rd(A_CCTL1); chk("overflow set", d, 32'h0103);
        repeat (20) @(posedge mclk);
        rd(A_CCTL1); chk("overflow kept", d, 32'h0103);
        wr(A_CCTL1, 16'h0000); rd(A_CCTL1); chk("overflow cleared", d, 32'h0);
        pulse(1); rd(A_CCR1 + 12'h008); chk("compare no capture", d, 32'h0);
        // disabled source ignored by vector
        wr(A_CCTL1 + 12'h018, 16'h0001); rd(A_IV); chk("vector disabled", d, 32'h0);
        // vector priority and read clearing
        wr(A_IMR, 16'h007F);
        for (int n = 0; n < 6; n++) wr(A_CCTL1 + 12'(8 * n), 16'h0011);
        wr(A_CTL, 16'h0003);
        repeat (2) @(posedge mclk);
        chk("irq pending", {31'h0, irq}, 32'h1);
        for (int i = 1; i <= 7; i++) begin
            rd(A_IV); chk("vector code", d, 32'(2 * i));
        end
        rd(A_IV); chk("vector empty", d, 32'h0);
        wr(A_ISR, 16'h007F);
        repeat (2) @(posedge mclk);
        chk("irq idle", {31'h0, irq}, 32'h0);
        // mask and status clear
        wr(A_CCTL1 + 12'h010, 16'h0100); pulse(2);
        wr(A_IMR, 16'h0000);
        repeat (2) @(posedge mclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(A_IMR, 16'h007F);
        repeat (2) @(posedge mclk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(A_ISR, 16'h0004);
        repeat (2) @(posedge mclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rd(A_ISR); chk("status cleared", d, 32'h0);
        // divider cascade
        for (int k = 0; k < 4; k++) begin
            wr(A_EX, 16'(ex[k]));
            wr(A_CTL, 16'((pre[k] << 6) | 16'h0014)); // clear after setup
            repeat (384) @(posedge mclk);
            wr(A_CTL, 16'(pre[k] << 6));
            rd(A_CNT);
            chk("count window", {31'h0, (d >= 384 / dv[k]) && (d <= 400 / dv[k] + 1)}, 32'h1);
        end
        // compare match
        wr(A_EX, 16'h0000);
        wr(A_CCR1 + 12'h008, 16'h0020); wr(A_CCR1 + 12'h010, 16'hF000);
        wr(A_CCTL1 + 12'h008, 16'h0000); wr(A_CCTL1 + 12'h010, 16'h0000);
        wr(A_CTL, 16'h0014);
        repeat (60) @(posedge mclk);
        wr(A_CTL, 16'h0000);
        rd(A_CCTL1 + 12'h008); chk("compare hit", d, 32'h1);
        rd(A_CCTL1 + 12'h010); chk("compare miss", d, 32'h0);
        end_sim();
    end
endmodule
